// >>> t1sig_pkg.sv
// Package for the T1 transmit signaling and per-slot control block.
// Assumes a single 40 MHz clock domain and a paged 8-bit processor port.
package t1sig_pkg;

	// -------------------------------------------------------------------------
	// Processor port map
	// -------------------------------------------------------------------------
	localparam logic [3:0] PAGE_SIG_LO  = 4'h5;
	localparam logic [3:0] PAGE_SIG_HI  = 4'h6;
	localparam logic [3:0] PAGE_CTL_LO  = 4'h7;
	localparam logic [3:0] PAGE_CTL_HI  = 4'h8;
	localparam logic [4:0] ADDR_BASE    = 5'h10;
	localparam logic [4:0] ADDR_HI_LAST = 5'h17;
	localparam int         NUM_CH       = 24;
	localparam int         CH_PER_PAGE  = 16;
	localparam logic [7:0] SIG_RESET    = 8'h00;
	localparam logic [7:0] CTL_RESET    = 8'h00;
	localparam logic [7:0] SIG_MASK     = 8'h0f;

	// -------------------------------------------------------------------------
	// Per-slot control word fields
	// -------------------------------------------------------------------------
	localparam int CTL_MSG   = 7;
	localparam int CTL_INV   = 6;
	localparam int CTL_RLOOP = 5;
	localparam int CTL_LLOOP = 4;
	localparam int CTL_TXTST = 3;
	localparam int CTL_RXTST = 2;
	localparam int CTL_RPSEL = 1;
	localparam int CTL_CLEAR = 0;

	// -------------------------------------------------------------------------
	// Signaling bit positions and superframe frames
	// -------------------------------------------------------------------------
	localparam int         SIG_A     = 3;
	localparam int         SIG_B     = 2;
	localparam int         SIG_C     = 1;
	localparam int         SIG_D     = 0;
	localparam int         ROB_BIT   = 0;
	localparam logic [4:0] FRAME_A   = 5'd6;
	localparam logic [4:0] FRAME_B   = 5'd12;
	localparam logic [4:0] FRAME_C   = 5'd18;
	localparam logic [4:0] FRAME_D   = 5'd24;

	// -------------------------------------------------------------------------
	// Test signals
	// -------------------------------------------------------------------------
	localparam logic [14:0] PRBS_SEED = 15'h7fff;
	localparam logic [63:0] DMW_TABLE = 64'h1e0b0b1e9e8b8b9e;
	localparam int          FIFO_DEPTH = 8;

	// -------------------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic [4:0] frame;
		logic [4:0] slot;
		logic [7:0] ctrl;
		logic [7:0] data;
	} t1sig_bp_s;

	typedef struct packed {
		logic [4:0] frame;
		logic [4:0] slot;
		logic [7:0] data;
	} t1sig_line_s;

endpackage

// >>> t1sig_fifo.sv
// Synchronous valid/ready FIFO held in flip-flops.
// Assumes one clock; push and pop may occur in the same cycle.
`timescale 1ns/100ps
module t1sig_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

endmodule

// >>> t1sig_core.sv
// Transmit robbed-bit signaling and per-time-slot control for a T1 framer.
// Assumes byte-wide slot streams tagged with DS1 slot (0..23) and frame (1..24).
//
// Contract
// - One four-bit transmit signaling word per channel, pages five and six.
// - Serial select high: signaling bits come from the processor-written register.
// - Serial select low: signaling is loaded from the serial control slot.
// - A bit goes in bit position eight of frame six.
// - B bit goes in bit position eight of frame twelve.
// - C bit goes in frame eighteen only in extended superframe mode.
// - D bit goes in frame twenty-four only in extended superframe mode.
// - Nibble select one takes signaling from serial bits seven to four.
// - Nibble select zero takes signaling from serial bits three to zero.
// - One control word per slot, pages seven and eight.
// - Message mode sends the message register instead of backplane data.
// - Inversion flips backplane data outbound and line data inbound.
// - Remote loopback sends received slot back out, still shown on backplane.
// - Local loopback returns transmit slot to receive side, still transmitted.
// - Transmit test sends milliwatt or fifteen-stage pseudo-random sequence.
// - Receive test drives milliwatt to backplane or feeds the sequence detector.
// - Clear channel suppresses robbed-bit signaling for that slot.
`timescale 1ns/100ps
module t1sig_core #(
	parameter int NUM_CH     = t1sig_pkg::NUM_CH,
	parameter int FIFO_DEPTH = t1sig_pkg::FIFO_DEPTH
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	// Processor port.
	input  wire logic                  cpu_cs,
	input  wire logic                  cpu_wr,
	input  wire logic [3:0]            cpu_page,
	input  wire logic [4:0]            cpu_addr,
	input  wire logic [7:0]            cpu_wdata,
	output logic      [7:0]            cpu_rdata,
	// Static controls held elsewhere in the framer.
	input  wire logic                  esf_mode,
	input  wire logic                  serial_nibble_select,
	input  wire logic                  test_signal_select,
	input  wire logic [7:0]            tx_message,
	// Backplane transmit side: data plus serial control byte.
	input  wire logic                  bp_valid,
	output logic                       bp_ready,
	input  wire t1sig_pkg::t1sig_bp_s  bp_word,
	// DS1 transmit side.
	output logic                       line_tx_valid,
	input  wire logic                  line_tx_ready,
	output t1sig_pkg::t1sig_line_s     line_tx_word,
	// DS1 receive side.
	input  wire logic                  line_rx_valid,
	input  wire t1sig_pkg::t1sig_line_s line_rx_word,
	// Backplane receive output and sequence detector feed.
	output logic                       backplane_out_valid,
	output t1sig_pkg::t1sig_line_s     backplane_data_out,
	output logic                       prbs_det_valid,
	output logic      [7:0]            prbs_det_data
);

	// -------------------------------------------------------------------------
	// Processor port decode
	// -------------------------------------------------------------------------
	logic       sig_hit;
	logic       ctl_hit;
	logic [4:0] cpu_ch;

	always_comb
	begin
		sig_hit = 1'b0;
		ctl_hit = 1'b0;
		cpu_ch  = '0;
		if (cpu_addr >= t1sig_pkg::ADDR_BASE &&
			(cpu_page == t1sig_pkg::PAGE_SIG_LO || cpu_page == t1sig_pkg::PAGE_CTL_LO))
		begin
			cpu_ch  = cpu_addr - t1sig_pkg::ADDR_BASE;
			sig_hit = (cpu_page == t1sig_pkg::PAGE_SIG_LO);
			ctl_hit = (cpu_page == t1sig_pkg::PAGE_CTL_LO);
		end
		else if (cpu_addr >= t1sig_pkg::ADDR_BASE && cpu_addr <= t1sig_pkg::ADDR_HI_LAST &&
			(cpu_page == t1sig_pkg::PAGE_SIG_HI || cpu_page == t1sig_pkg::PAGE_CTL_HI))
		begin
			cpu_ch  = cpu_addr - t1sig_pkg::ADDR_BASE + 5'(t1sig_pkg::CH_PER_PAGE);
			sig_hit = (cpu_page == t1sig_pkg::PAGE_SIG_HI);
			ctl_hit = (cpu_page == t1sig_pkg::PAGE_CTL_HI);
		end
	end

	// -------------------------------------------------------------------------
	// Per-channel storage
	// -------------------------------------------------------------------------
	logic [3:0] sig_reg  [NUM_CH];
	logic [7:0] ctl_reg  [NUM_CH];
	logic [7:0] rx_hold_reg [NUM_CH];
	logic [7:0] tx_hold_reg [NUM_CH];

	t1sig_pkg::t1sig_bp_s   fifo_word;
	t1sig_pkg::t1sig_line_s tx_next;
	logic                   fifo_valid;
	logic                   fifo_pop;
	logic [7:0]             tx_raw;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1)
		begin : g_ch
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
				begin
					sig_reg[g] <= t1sig_pkg::SIG_RESET[3:0];
					ctl_reg[g] <= t1sig_pkg::CTL_RESET;
				end
				else if (cpu_cs && cpu_wr && cpu_ch == 5'(g))
				begin
					if (sig_hit)
						sig_reg[g] <= cpu_wdata[3:0];
					if (ctl_hit)
						ctl_reg[g] <= cpu_wdata;
				end
			end

			// Last byte seen each way, kept for the two loopbacks.
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
				begin
					rx_hold_reg[g] <= 8'h00;
					tx_hold_reg[g] <= 8'h00;
				end
				else
				begin
					if (line_rx_valid && line_rx_word.slot == 5'(g))
						rx_hold_reg[g] <= line_rx_word.data;
					if (fifo_pop && fifo_word.slot == 5'(g))
						tx_hold_reg[g] <= tx_raw;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cpu_rdata <= 8'h00;
		else if (cpu_cs && !cpu_wr && sig_hit)
			cpu_rdata <= {4'h0, sig_reg[cpu_ch]} & t1sig_pkg::SIG_MASK;
		else if (cpu_cs && !cpu_wr && ctl_hit)
			cpu_rdata <= ctl_reg[cpu_ch];
		else
			cpu_rdata <= 8'h00;
	end

	// -------------------------------------------------------------------------
	// Backplane buffer
	// -------------------------------------------------------------------------
	// Back-pressure from the line side fills this FIFO and then stalls the
	// backplane source through bp_ready.
	t1sig_fifo #(
		.WIDTH ($bits(t1sig_pkg::t1sig_bp_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (bp_valid),
		.in_ready  (bp_ready),
		.in_data   (bp_word),
		.out_valid (fifo_valid),
		.out_ready (!line_tx_valid || line_tx_ready),
		.out_data  (fifo_word)
	);

	assign fifo_pop = fifo_valid && (!line_tx_valid || line_tx_ready);

	// -------------------------------------------------------------------------
	// Test signal sources
	// -------------------------------------------------------------------------
	function automatic logic [22:0] prbs_step8(input logic [14:0] s);
		logic [14:0] st;
		logic [7:0]  ob;
		logic        b;
		st = s;
		ob = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			b  = st[14] ^ st[13];
			st = {st[13:0], b};
			ob = {ob[6:0], b};
		end
		return {st, ob};
	endfunction

	logic [14:0] prbs_reg;
	logic [22:0] prbs_nx;
	logic [2:0]  dmw_phase_reg;
	logic [4:0]  last_frame_reg;
	logic [7:0]  dmw_byte;

	assign prbs_nx  = prbs_step8(prbs_reg);
	assign dmw_byte = t1sig_pkg::DMW_TABLE[8*(7-dmw_phase_reg) +: 8];

	// The milliwatt sample steps once per transmit frame, after its first word
	// pops, so that word carries the old sample and the rest of the frame the new one.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dmw_phase_reg  <= 3'h0;
			last_frame_reg <= 5'h00;
		end
		else if (fifo_pop && fifo_word.frame != last_frame_reg)
		begin
			dmw_phase_reg  <= dmw_phase_reg + 3'h1;
			last_frame_reg <= fifo_word.frame;
		end
	end

	// -------------------------------------------------------------------------
	// Transmit slot processing
	// -------------------------------------------------------------------------
	logic       tx_ch_ok;
	logic [7:0] tx_ctl;
	logic [3:0] tx_sig;
	logic [3:0] serial_nib;
	logic       rob_en;
	logic       rob_bit;
	logic       use_prbs;

	always_comb
	begin
		tx_ch_ok   = (fifo_word.slot < 5'(NUM_CH));
		tx_ctl     = tx_ch_ok ? ctl_reg[fifo_word.slot] : 8'h00;
		serial_nib = serial_nibble_select ? fifo_word.ctrl[7:4]
			: fifo_word.ctrl[3:0];
		// Serial signaling is taken from the byte in flight, so there is no
		// frame of lag between the control stream and the line.
		tx_sig     = tx_ctl[t1sig_pkg::CTL_RPSEL] ? sig_reg[fifo_word.slot]
			: serial_nib;
		use_prbs   = 1'b0;
		if (!tx_ch_ok)
			tx_raw = fifo_word.data;
		else if (tx_ctl[t1sig_pkg::CTL_TXTST])
		begin
			use_prbs = !test_signal_select;
			tx_raw   = test_signal_select ? dmw_byte : prbs_nx[7:0];
		end
		else if (tx_ctl[t1sig_pkg::CTL_RLOOP])
			tx_raw = rx_hold_reg[fifo_word.slot];
		else if (tx_ctl[t1sig_pkg::CTL_MSG])
			tx_raw = tx_message;
		else if (tx_ctl[t1sig_pkg::CTL_INV])
			tx_raw = ~fifo_word.data;
		else
			tx_raw = fifo_word.data;

		rob_en  = 1'b0;
		rob_bit = 1'b0;
		if (fifo_word.frame == t1sig_pkg::FRAME_A)
		begin
			rob_en  = 1'b1;
			rob_bit = tx_sig[t1sig_pkg::SIG_A];
		end
		else if (fifo_word.frame == t1sig_pkg::FRAME_B)
		begin
			rob_en  = 1'b1;
			rob_bit = tx_sig[t1sig_pkg::SIG_B];
		end
		else if (esf_mode && fifo_word.frame == t1sig_pkg::FRAME_C)
		begin
			rob_en  = 1'b1;
			rob_bit = tx_sig[t1sig_pkg::SIG_C];
		end
		else if (esf_mode && fifo_word.frame == t1sig_pkg::FRAME_D)
		begin
			rob_en  = 1'b1;
			rob_bit = tx_sig[t1sig_pkg::SIG_D];
		end

		tx_next.frame = fifo_word.frame;
		tx_next.slot  = fifo_word.slot;
		tx_next.data  = tx_raw;
		if (tx_ch_ok && rob_en && !tx_ctl[t1sig_pkg::CTL_CLEAR])
			tx_next.data[t1sig_pkg::ROB_BIT] = rob_bit;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			prbs_reg <= t1sig_pkg::PRBS_SEED;
		else if (fifo_pop && use_prbs)
			prbs_reg <= prbs_nx[22:8];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			line_tx_valid <= 1'b0;
		else if (fifo_pop)
			line_tx_valid <= 1'b1;
		else if (line_tx_ready)
			line_tx_valid <= 1'b0;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			line_tx_word <= '0;
		else if (fifo_pop)
			line_tx_word <= tx_next;
	end

	// -------------------------------------------------------------------------
	// Receive slot processing
	// -------------------------------------------------------------------------
	logic       rx_ch_ok;
	logic [7:0] rx_ctl;
	logic [7:0] rx_out;
	logic       rx_to_det;

	always_comb
	begin
		rx_ch_ok  = (line_rx_word.slot < 5'(NUM_CH));
		rx_ctl    = rx_ch_ok ? ctl_reg[line_rx_word.slot] : 8'h00;
		rx_to_det = rx_ctl[t1sig_pkg::CTL_RXTST] && !test_signal_select;
		if (!rx_ch_ok)
			rx_out = line_rx_word.data;
		else if (rx_ctl[t1sig_pkg::CTL_RXTST] && test_signal_select)
			rx_out = dmw_byte;
		else if (rx_ctl[t1sig_pkg::CTL_LLOOP])
			rx_out = tx_hold_reg[line_rx_word.slot];
		else if (rx_ctl[t1sig_pkg::CTL_INV])
			rx_out = ~line_rx_word.data;
		else
			rx_out = line_rx_word.data;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			backplane_out_valid <= 1'b0;
			prbs_det_valid      <= 1'b0;
		end
		else
		begin
			backplane_out_valid <= line_rx_valid;
			prbs_det_valid      <= line_rx_valid && rx_to_det;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			backplane_data_out <= '0;
			prbs_det_data      <= 8'h00;
		end
		else if (line_rx_valid)
		begin
			backplane_data_out.frame <= line_rx_word.frame;
			backplane_data_out.slot  <= line_rx_word.slot;
			backplane_data_out.data  <= rx_out;
			if (rx_to_det)
				prbs_det_data <= line_rx_word.data;
		end
	end

endmodule

// >>> t1sig_core_properties.sv
// Port-level properties of the transmit signaling and slot control block.
// Assumes it is bound to t1sig_core and sees only that module's ports.
`timescale 1ns/100ps
module t1sig_core_properties #(
	parameter int NUM_CH     = 24,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic                    clk,
	input wire logic                    nrst,
	input wire logic                    cpu_cs,
	input wire logic                    cpu_wr,
	input wire logic [3:0]              cpu_page,
	input wire logic [4:0]              cpu_addr,
	input wire logic [7:0]              cpu_wdata,
	input wire logic [7:0]              cpu_rdata,
	input wire logic                    line_tx_valid,
	input wire logic                    line_tx_ready,
	input wire t1sig_pkg::t1sig_line_s  line_tx_word,
	input wire logic                    line_rx_valid,
	input wire t1sig_pkg::t1sig_line_s  line_rx_word,
	input wire logic                    backplane_out_valid,
	input wire t1sig_pkg::t1sig_line_s  backplane_data_out,
	input wire logic                    prbs_det_valid,
	input wire logic [7:0]              prbs_det_data
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// --------------------------------------------------------------------
	// Processor port
	// --------------------------------------------------------------------
	logic mapped;
	assign mapped = cpu_addr[4] && (cpu_page == 4'h5 || cpu_page == 4'h7
		|| ((cpu_page == 4'h6 || cpu_page == 4'h8) && !cpu_addr[3]));

	sequence wr_s(logic [3:0] lo, logic [3:0] hi);
		cpu_cs && cpu_wr && mapped && (cpu_page == lo || cpu_page == hi);
	endsequence
	sequence rd_same_s;
		cpu_cs && !cpu_wr && $stable(cpu_page) && $stable(cpu_addr);
	endsequence
	sequence stalled_s;
		line_tx_valid && !line_tx_ready;
	endsequence

	sig_readback_a: assert property (wr_s(4'h5, 4'h6) ##1 rd_same_s
		|=> cpu_rdata == ($past(cpu_wdata, 2) & 8'h0f)) else $error("signaling readback wrong");
	ctl_readback_a: assert property (wr_s(4'h7, 4'h8) ##1 rd_same_s
		|=> cpu_rdata == $past(cpu_wdata, 2)) else $error("slot control readback wrong");
	unmapped_read_a: assert property (cpu_cs && !cpu_wr && !mapped
		|=> cpu_rdata == 8'h00) else $error("unmapped read not zero");
	idle_rdata_a: assert property (!cpu_cs || cpu_wr |=> cpu_rdata == 8'h00)
		else $error("read data without a read");
	sig_upper_a: assert property (cpu_cs && !cpu_wr && (cpu_page == 4'h5 || cpu_page == 4'h6)
		|=> cpu_rdata[7:4] == 4'h0) else $error("signaling upper bits not zero");

	// --------------------------------------------------------------------
	// Streams
	// --------------------------------------------------------------------
	rx_pulse_a: assert property (line_rx_valid |=> backplane_out_valid)
		else $error("received slot not presented");
	rx_quiet_a: assert property (!line_rx_valid |=> !backplane_out_valid)
		else $error("backplane output without received slot");
	det_feed_a: assert property (prbs_det_valid |-> backplane_out_valid
		&& prbs_det_data == $past(line_rx_word[7:0])) else $error("detector feed wrong");
	tx_hold_a: assert property (stalled_s |=> line_tx_valid && $stable(line_tx_word))
		else $error("transmit word dropped while stalled");
endmodule

bind t1sig_core t1sig_core_properties #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH)) i_props (
	.clk(clk), .nrst(nrst), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr), .cpu_page(cpu_page),
	.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
	.line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready), .line_tx_word(line_tx_word),
	.line_rx_valid(line_rx_valid), .line_rx_word(line_rx_word),
	.backplane_out_valid(backplane_out_valid), .backplane_data_out(backplane_data_out),
	.prbs_det_valid(prbs_det_valid), .prbs_det_data(prbs_det_data));

// >>> t1sig_line_sink.sv
// Line-side sink model: takes transmit words at a pace set by the bench.
// Assumes stall is driven from the same clock; ready lags stall by one cycle.
`timescale 1ns/100ps
module t1sig_line_sink (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   stall,
	input  wire logic                   tx_valid,
	input  wire t1sig_pkg::t1sig_line_s tx_word,
	output logic                        tx_ready,
	output logic                        got,
	output t1sig_pkg::t1sig_line_s      got_word
);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_ready <= 1'b0;
			got      <= 1'b0;
			got_word <= '0;
		end
		else
		begin
			tx_ready <= !stall;
			got      <= tx_valid && tx_ready;
			got_word <= tx_word;
		end
	end
endmodule

// >>> tb.sv
// Self-checking bench for the transmit signaling and slot control block.
// Assumes a 40 MHz clock and the line sink model on the transmit side.
`timescale 1ns/100ps
module tb;
	localparam int DEPTH = 8;
	localparam int LIMIT = 20000;
	logic                   clk = 1'b0;
	logic                   nrst = 1'b0;
	logic                   cpu_cs = 1'b0;
	logic                   cpu_wr = 1'b0;
	logic [3:0]             cpu_page = 4'h0;
	logic [4:0]             cpu_addr = 5'h00;
	logic [7:0]             cpu_wdata = 8'h00;
	logic [7:0]             cpu_rdata;
	logic                   esf_mode = 1'b0;
	logic                   nib = 1'b0;
	logic                   tsel = 1'b0;
	logic [7:0]             tx_msg = 8'h00;
	logic                   bp_valid = 1'b0;
	logic                   bp_ready;
	t1sig_pkg::t1sig_bp_s   bp_word = '0;
	logic                   tx_valid;
	logic                   tx_ready;
	t1sig_pkg::t1sig_line_s tx_word;
	logic                   rx_valid = 1'b0;
	t1sig_pkg::t1sig_line_s rx_word = '0;
	logic                   bo_valid;
	t1sig_pkg::t1sig_line_s bo_word;
	logic                   det_valid;
	logic [7:0]             det_data;
	logic                   stall = 1'b0;
	logic                   hold = 1'b0;
	logic                   rnd = 1'b0;
	logic                   got;
	t1sig_pkg::t1sig_line_s got_word;
	logic [7:0]             ctl_m [24];
	logic [3:0]             sig_m [24];
	logic [7:0]             rx_last [24];
	logic [17:0]            q [$];
	logic [7:0]             c;
	logic [7:0]             d;
	logic [7:0]             tv = 8'h00;
	logic [4:0]             fr;
	int                     i;
	int                     n;
	int                     cyc = 0;
	int                     fail_count = 0;
	int                     n_checks = 0;

	t1sig_core #(.NUM_CH(24), .FIFO_DEPTH(DEPTH)) i_dut (
		.clk(clk), .nrst(nrst), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr), .cpu_page(cpu_page),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .esf_mode(esf_mode),
		.serial_nibble_select(nib), .test_signal_select(tsel), .tx_message(tx_msg),
		.bp_valid(bp_valid), .bp_ready(bp_ready), .bp_word(bp_word), .line_tx_valid(tx_valid),
		.line_tx_ready(tx_ready), .line_tx_word(tx_word), .line_rx_valid(rx_valid),
		.line_rx_word(rx_word), .backplane_out_valid(bo_valid), .backplane_data_out(bo_word),
		.prbs_det_valid(det_valid), .prbs_det_data(det_data));
	t1sig_line_sink i_sink (.clk(clk), .nrst(nrst), .stall(stall), .tx_valid(tx_valid),
		.tx_word(tx_word), .tx_ready(tx_ready), .got(got), .got_word(got_word));

	always #12.5 clk = ~clk;

	// --------------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------------
	task automatic finish_test();
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [19:0] g, input logic [19:0] e);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	function automatic logic [3:0] pg(input int ch, input logic [3:0] base);
		return ch < 16 ? base : base + 4'h1;
	endfunction
	function automatic logic [4:0] ad(input int ch);
		return 5'h10 + 5'(ch % 16);
	endfunction
	function automatic logic [7:0] exp_tx(input int ch, input logic [7:0] cb, input logic [7:0] x);
		logic [7:0] k;
		logic [3:0] g;
		k = ctl_m[ch];
		x = k[3] ? tv : k[5] ? rx_last[ch] : k[7] ? tx_msg : k[6] ? ~x : x;
		g = k[1] ? sig_m[ch] : nib ? cb[7:4] : cb[3:0];
		if (!k[0] && (fr == 5'd6 || fr == 5'd12 || (esf_mode && (fr == 5'd18 || fr == 5'd24))))
			x[0] = g[4 - fr / 6];
		return x;
	endfunction
	task automatic rd(input logic [3:0] p, input logic [4:0] a, input logic [7:0] e);
		@(posedge clk);
		cpu_cs <= 1'b1;
		cpu_wr <= 1'b0;
		cpu_page <= p;
		cpu_addr <= a;
		@(posedge clk);
		cpu_cs <= 1'b0;
		#1;
		check(cpu_rdata, e);
	endtask
	task automatic wr_rd(input logic [3:0] p, input logic [4:0] a, input logic [7:0] v,
		input logic [7:0] e);
		@(posedge clk);
		cpu_cs <= 1'b1;
		cpu_wr <= 1'b1;
		cpu_page <= p;
		cpu_addr <= a;
		cpu_wdata <= v;
		rd(p, a, e);
	endtask
	task automatic set_ctl(input int ch, input logic [7:0] v);
		ctl_m[ch] = v;
		wr_rd(pg(ch, 4'h7), ad(ch), v, v);
	endtask
	task automatic offer(input int ch, input logic [7:0] cb, input logic [7:0] v);
		q.push_back({fr, 5'(ch), exp_tx(ch, cb, v)});
		bp_valid <= 1'b1;
		bp_word <= '{frame: fr, slot: 5'(ch), ctrl: cb, data: v};
	endtask
	task automatic acc();
		int k;
		k = 0;
		@(negedge clk);
		while (!bp_ready && k < 500)
		begin
			@(negedge clk);
			k++;
		end
		if (!bp_ready)
			fail_count++;
		@(posedge clk);
	endtask
	task automatic send(input int ch, input logic [7:0] cb, input logic [7:0] v);
		int k;
		@(posedge clk);
		offer(ch, cb, v);
		acc();
		bp_valid <= 1'b0;
		for (k = 0; k < 300 && q.size() != 0; k++)
			@(posedge clk);
		if (q.size() != 0)
			fail_count++;
	endtask
	task automatic rx(input int ch, input logic [7:0] v, input logic [7:0] e, input logic dv);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_word <= '{frame: 5'd1, slot: 5'(ch), data: v};
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_last[ch] = v;
		@(negedge clk);
		check({bo_valid, bo_word}, {1'b1, 5'd1, 5'(ch), e});
		check({det_valid, dv ? det_data : 8'h00}, {dv, dv ? v : 8'h00});
	endtask

	always @(posedge clk)
		stall <= hold | (rnd & 1'($urandom));
	always @(posedge clk)
		if (got)
			check(got_word, q.size() != 0 ? q.pop_front() : 18'h3ffff);
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			fail_count++;
			finish_test();
		end
	end

	// --------------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------------
	initial
	begin
		void'($urandom(49553));
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (i = 0; i < 24; i++)
		begin
			rd(pg(i, 4'h5), ad(i), 8'h00);
			rd(pg(i, 4'h7), ad(i), 8'h00);
			sig_m[i] = 4'($urandom);
			wr_rd(pg(i, 4'h5), ad(i), {4'($urandom), sig_m[i]}, {4'h0, sig_m[i]});
		end
		rd(4'h6, 5'h18, 8'h00);
		wr_rd(4'h8, 5'h1f, 8'hff, 8'h00);
		rd(4'h5, 5'h0f, 8'h00);
		rd(4'h9, 5'h10, 8'h00);
		for (i = 0; i < 24; i++)
		begin
			@(posedge clk);
			tsel <= 1'($urandom);
			c = 8'($urandom) & 8'h44;
			set_ctl(i, c);
			d = 8'($urandom);
			rx(i, d, c[2] && tsel ? t1sig_pkg::DMW_TABLE[63:56] : c[6] ? ~d : d,
				c[2] && !tsel);
		end
		// No transmit word has passed yet, so the sequence sits at its seed
		// and the milliwatt sample at its first step.
		@(posedge clk);
		tsel <= 1'b0;
		fr = 5'd6;
		set_ctl(7, 8'h09);
		tv = 8'h00;
		send(7, 8'hff, 8'h55);
		tv = 8'h02;
		send(7, 8'hff, 8'h55);
		@(posedge clk);
		tsel <= 1'b1;
		tv = t1sig_pkg::DMW_TABLE[55:48];
		send(7, 8'hff, 8'h55);
		rnd = 1'b1;
		for (n = 0; n < 150; n++)
		begin
			i = $urandom % 24;
			set_ctl(i, 8'($urandom) & 8'hd7);
			@(posedge clk);
			esf_mode <= 1'($urandom);
			nib <= 1'($urandom);
			tx_msg <= 8'($urandom);
			fr = ($urandom % 2) ? 5'(6 * (1 + $urandom % 4)) : 5'(1 + $urandom % 24);
			send(i, 8'($urandom), 8'($urandom));
		end
		set_ctl(3, 8'h20);
		rx(3, 8'h5a, 8'h5a, 1'b0);
		fr = 5'd6;
		send(3, 8'h00, 8'h00);
		set_ctl(5, 8'h10);
		send(5, 8'h00, 8'ha7);
		rx(5, 8'h00, 8'ha7, 1'b0);
		rnd = 1'b0;
		hold = 1'b1;
		fr = 5'd1;
		set_ctl(0, 8'h01);
		repeat (3) @(posedge clk);
		for (n = 0; n <= DEPTH + 1; n++)
		begin
			offer(0, 8'h00, 8'(n));
			if (n > DEPTH)
			begin
				repeat (6) @(negedge clk);
				check(20'(bp_ready), 20'h0);
				hold = 1'b0;
			end
			acc();
		end
		bp_valid <= 1'b0;
		repeat (40) @(posedge clk);
		check(20'(q.size()), 20'h0);
		finish_test();
	end
endmodule
